//--- hw/mcr_cfg.svh
// register offsets, field positions, reset values, masks and field codes for the motor config bank
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

`define MCR_ADDR_W           8
`define MCR_DATA_W           16
`define MCR_OFS_RUN_INHIBIT  8'h60
`define MCR_OFS_SETUP_A      8'h90
`define MCR_OFS_SETUP_B      8'h91
`define MCR_UNUSED1_LO       8'h37
`define MCR_UNUSED1_HI       8'h5F
`define MCR_UNUSED2_LO       8'h61
`define MCR_UNUSED2_HI       8'h8F
`define MCR_RESET_VAL        16'h0000
`define MCR_BIT_MOTOR_DISABLE_CTL      15
`define MCR_MASK_SETUP_A     16'hFFFF
`define MCR_MASK_SETUP_B     16'h7FFF
`define MCR_DITHER_NONE      2'h0
`define MCR_DITHER_5PCT      2'h1
`define MCR_DITHER_10PCT     2'h2
`define MCR_DITHER_15PCT     2'h3
`define MCR_GATE_BOTH        2'h0
`define MCR_GATE_CLOSED      2'h1
`define MCR_GATE_CLOSED_1ST  2'h2

`endif

//--- hw/mcr_pkg.sv
// types shared by the motor config bank
package mcr_pkg;

    typedef struct packed {
        logic [1:0] dither_select;
        logic [1:0] tach_loop_gating;
        logic [3:0] tach_pole_divider;
        logic       cycle_adjust_select;
        logic [2:0] resistance_shift_count;
        logic [3:0] resistance_mantissa;
    } mcr_setup_a_type;

    typedef struct packed {
        logic       reserved;
        logic [2:0] bemf_const_shift;
        logic [3:0] bemf_const_mantissa;
        logic       advance_mode_select;
        logic [2:0] advance_time_shift;
        logic [3:0] advance_time_mantissa;
    } mcr_setup_b_type;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } mcr_req_type;

    typedef enum logic [2:0] {
        MCR_TACH_IDLE = 3'b001,
        MCR_TACH_OPEN = 3'b010,
        MCR_TACH_RUN  = 3'b100
    } mcr_tach_state_type;

endpackage : mcr_pkg

//--- hw/mcr_tach_div.sv
// tachometer divider: toggles output every n+1 electrical pulses
`timescale 1ns/1ps
`default_nettype none
module mcr_tach_div #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // control
    input  wire logic             enable,
    input  wire logic [DIV_W-1:0] divide_n,
    input  wire logic             elec_pulse,
    // output
    output logic                  tach_out_ff
);
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
        $error("mcr_tach_div: DIV_W out of range");
    end

    logic [DIV_W-1:0] count_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_ff    <= '0;
            tach_out_ff <= 1'b0;
        end else if (!enable) begin
            count_ff    <= '0;
        end else if (elec_pulse) begin
            if (count_ff >= divide_n) begin
                count_ff    <= '0;
                tach_out_ff <= ~tach_out_ff;
            end else begin
                count_ff    <= count_ff + 1'b1;
            end
        end
    end
endmodule : mcr_tach_div
`default_nettype wire

//--- hw/mcr_bank.sv
// motor configuration register bank with decoded parameters
// How it works
// [RULE_01] 0x37..0x5F unused, no function
// [RULE_02] 0x61..0x8F unused, no function
// [RULE_03] disable bit 15 write-only, reset zero
// [RULE_04] disable set stops motor control
// [RULE_05] host sets disable before nvm programming
// [RULE_06] bits 15:14 choose dither 0/5/10/15 pct
// [RULE_07] bits 13:12 gate tach by loop state
// [RULE_08] bits 11:8 divide tach by n+1
// [RULE_09] bit 7 full or half cycle adjust
// [RULE_10] resistance is mantissa shifted by count
// [RULE_11] host quantizes resistance, picks shift
// [RULE_12] bits 3:0 hold resistance mantissa
// [RULE_13] bemf constant is mantissa shifted by count
// [RULE_14] advance time is mantissa shifted by count
// [RULE_15] bit 7 chooses fixed or scaled advance
// [RULE_16] single-access address 0x90 targets word a
// [RULE_17] unused reads zero, writes ignored
// [RULE_18] reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "mcr_cfg.svh"
module mcr_bank #(
    parameter int ADDR_W = `MCR_ADDR_W,
    parameter int DATA_W = `MCR_DATA_W
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    // register access from serial bus engine
    input  wire mcr_pkg::mcr_req_type   req,
    output logic [DATA_W-1:0]           rdata_ff,
    output logic                        rvalid_ff,
    // nvm single-access address
    input  wire logic [ADDR_W-1:0]      nvm_single_access_addr,
    output logic                        nvm_target_setup_a_ff,
    // motor status
    input  wire logic                   closed_loop,
    input  wire logic                   elec_pulse,
    // decoded controls
    output logic                        motor_run_ff,
    output logic [1:0]                  dither_select_ff,
    output logic [4:0]                  dither_pct_ff,
    output logic                        cycle_adjust_select_ff,
    output logic [18:0]                 resistance_param_ff,
    output logic [18:0]                 bemf_const_ff,
    output logic [18:0]                 advance_time_ff,
    output logic                        advance_mode_select_ff,
    output logic                        tach_output
);
    if (ADDR_W != 8 || DATA_W != 16) begin : g_bad_width
        $error("mcr_bank: only 8-bit address, 16-bit data supported");
    end

    logic                    motor_disable_ctl_ff;
    mcr_pkg::mcr_setup_a_type setup_a_ff;
    mcr_pkg::mcr_setup_b_type setup_b_ff;
    mcr_pkg::mcr_tach_state_type tach_state_ff;
    logic                    tach_enable;
    logic [DATA_W-1:0]       nxt_rdata;

    // per-entry operands of the mantissa shifters
    localparam int N_SHIFTED = 3;
    localparam int PARAM_W   = 19;
    logic [3:0]              shift_mant [N_SHIFTED];
    logic [2:0]              shift_cnt  [N_SHIFTED];
    logic [PARAM_W-1:0]      shifted    [N_SHIFTED];

    // motor disable control
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            motor_disable_ctl_ff <= 1'b0;
        end else if (req.wr_en && req.addr == `MCR_OFS_RUN_INHIBIT) begin
            motor_disable_ctl_ff <= req.wdata[`MCR_BIT_MOTOR_DISABLE_CTL]; // RULE_03
        end
    end

    // configuration words; addresses other than these and 0x60 have no storage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            setup_a_ff <= `MCR_RESET_VAL;
            setup_b_ff <= `MCR_RESET_VAL;
        end else if (req.wr_en) begin
            case (req.addr)
                `MCR_OFS_SETUP_A: setup_a_ff <= req.wdata & `MCR_MASK_SETUP_A;
                `MCR_OFS_SETUP_B: setup_b_ff <= req.wdata & `MCR_MASK_SETUP_B; // RULE_18
                default: ; // RULE_01 RULE_02 RULE_17
            endcase
        end
    end

    // read mux
    always_comb begin
        nxt_rdata = '0;
        case (req.addr)
            `MCR_OFS_RUN_INHIBIT: nxt_rdata = '0; // RULE_03 RULE_18
            `MCR_OFS_SETUP_A:     nxt_rdata = setup_a_ff;
            `MCR_OFS_SETUP_B:     nxt_rdata = setup_b_ff & `MCR_MASK_SETUP_B;
            default:              nxt_rdata = '0; // RULE_01 RULE_02 RULE_17
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req.rd_en;
            if (req.rd_en) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // nvm individual target decode
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            nvm_target_setup_a_ff <= 1'b0;
        end else begin
            nvm_target_setup_a_ff <= (nvm_single_access_addr == `MCR_OFS_SETUP_A); // RULE_16
        end
    end

    // motor run follows the inverted disable control one edge later
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            motor_run_ff <= 1'b0;
        end else begin
            motor_run_ff <= ~motor_disable_ctl_ff; // RULE_04
        end
    end

    // dither selection and its percentage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dither_select_ff <= `MCR_DITHER_NONE;
            dither_pct_ff    <= 5'h00;
        end else begin
            dither_select_ff <= setup_a_ff.dither_select;
            case (setup_a_ff.dither_select) // RULE_06
                `MCR_DITHER_NONE:  dither_pct_ff <= 5'h00;
                `MCR_DITHER_5PCT:  dither_pct_ff <= 5'h05;
                `MCR_DITHER_10PCT: dither_pct_ff <= 5'h0A;
                default:           dither_pct_ff <= 5'h0F;
            endcase
        end
    end

    // single-bit mode selects
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cycle_adjust_select_ff <= 1'b0;
            advance_mode_select_ff <= 1'b0;
        end else begin
            cycle_adjust_select_ff <= setup_a_ff.cycle_adjust_select; // RULE_09
            advance_mode_select_ff <= setup_b_ff.advance_mode_select; // RULE_15
        end
    end

    // mantissa shifted by count: resistance, bemf constant, advance time
    assign shift_mant[0] = setup_a_ff.resistance_mantissa; // RULE_12
    assign shift_cnt[0]  = setup_a_ff.resistance_shift_count;
    assign shift_mant[1] = setup_b_ff.bemf_const_mantissa;
    assign shift_cnt[1]  = setup_b_ff.bemf_const_shift;
    assign shift_mant[2] = setup_b_ff.advance_time_mantissa;
    assign shift_cnt[2]  = setup_b_ff.advance_time_shift;

    for (genvar g = 0; g < N_SHIFTED; g++) begin : g_shift
        logic [PARAM_W-1:0] value_ff;
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                value_ff <= '0;
            end else begin
                value_ff <= PARAM_W'(shift_mant[g]) << shift_cnt[g]; // RULE_10 RULE_13 RULE_14
            end
        end
        assign shifted[g] = value_ff;
    end

    assign resistance_param_ff = shifted[0];
    assign bemf_const_ff       = shifted[1];
    assign advance_time_ff     = shifted[2];

    // tach loop-state tracking: first open-loop run until first closed loop
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tach_state_ff <= mcr_pkg::MCR_TACH_IDLE;
        end else if (motor_disable_ctl_ff) begin
            tach_state_ff <= mcr_pkg::MCR_TACH_IDLE;
        end else begin
            case (tach_state_ff)
                mcr_pkg::MCR_TACH_IDLE: tach_state_ff <= mcr_pkg::MCR_TACH_OPEN;
                mcr_pkg::MCR_TACH_OPEN: if (closed_loop) tach_state_ff <= mcr_pkg::MCR_TACH_RUN;
                mcr_pkg::MCR_TACH_RUN:  tach_state_ff <= mcr_pkg::MCR_TACH_RUN;
                default:                tach_state_ff <= mcr_pkg::MCR_TACH_IDLE;
            endcase
        end
    end

    // tach gating by loop state, forced off while disabled
    always_comb begin
        case (setup_a_ff.tach_loop_gating) // RULE_07
            `MCR_GATE_BOTH:       tach_enable = 1'b1;
            `MCR_GATE_CLOSED:     tach_enable = closed_loop;
            `MCR_GATE_CLOSED_1ST: tach_enable = closed_loop || (tach_state_ff == mcr_pkg::MCR_TACH_OPEN);
            default:              tach_enable = 1'b0;
        endcase
        tach_enable = tach_enable & ~motor_disable_ctl_ff; // RULE_04
    end

    // tach divider
    mcr_tach_div #(
        .DIV_W (4)
    ) u_tach (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .enable      (tach_enable),
        .divide_n    (setup_a_ff.tach_pole_divider), // RULE_08
        .elec_pulse  (elec_pulse),
        .tach_out_ff (tach_output)
    );
endmodule : mcr_bank
`default_nettype wire

//--- bench/mcr_host_model.sv
// host side model issuing register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model (
    // clock
    input  wire logic                 clk_sys,
    // request to the bank
    output var mcr_pkg::mcr_req_type  req
);
    initial req = '0;
    // idle edge first, then a one-cycle request; idle lines then show inverted values
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk_sys) #1;
        req = '{w, !w, ad, d};
        @(posedge clk_sys) #1;
        req = '{1'b0, 1'b0, ~ad, ~d};
    endtask : xfer
    // truncating split of a resistance code into shift and mantissa
    function automatic logic [6:0] quant(input logic [10:0] c);
        for (int s = 0; s < 8; s++)
            if ((c >> s) < 11'h010) return {3'(s), 4'(c >> s)};
        return 7'h7F;
    endfunction : quant
endmodule : mcr_host_model
`default_nettype wire

//--- bench/mcr_bank_asserts.sv
// concurrent checks on the motor config bank ports
`timescale 1ns/1ps
`default_nettype none
module mcr_bank_asserts #(parameter int ADDR_W = 8, parameter int DATA_W = 16) (
    // clock, reset and flags
    input wire logic clk_sys, reset, rvalid_ff, closed_loop, elec_pulse, tach_output, nvm_target_setup_a_ff,
    input wire logic motor_run_ff, cycle_adjust_select_ff, advance_mode_select_ff,
    // buses and fields
    input wire mcr_pkg::mcr_req_type req,
    input wire logic [DATA_W-1:0] rdata_ff,
    input wire logic [ADDR_W-1:0] nvm_single_access_addr,
    input wire logic [1:0] dither_select_ff,
    input wire logic [4:0] dither_pct_ff,
    input wire logic [18:0] resistance_param_ff, bemf_const_ff, advance_time_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [15:0] wdata_d1_ff;
    logic [15:0] wdata_d2_ff;
    // write data two edges back, when decoded outputs show it
    always_ff @(posedge clk_sys) begin
        wdata_d1_ff <= req.wdata;
        wdata_d2_ff <= wdata_d1_ff;
    end
    property p_run;
        req.wr_en && req.addr == 8'h60 |-> ##2 motor_run_ff == !wdata_d2_ff[15];
    endproperty
    property p_a;
        req.wr_en && req.addr == 8'h90 |-> ##2 dither_select_ff == wdata_d2_ff[15:14]
            && dither_pct_ff == 5'(wdata_d2_ff[15:14]) * 5'h05 && cycle_adjust_select_ff == wdata_d2_ff[7]
            && resistance_param_ff == 19'(wdata_d2_ff[3:0]) << wdata_d2_ff[6:4];
    endproperty
    property p_b;
        req.wr_en && req.addr == 8'h91 |-> ##2 advance_mode_select_ff == wdata_d2_ff[7]
            && bemf_const_ff == 19'(wdata_d2_ff[11:8]) << wdata_d2_ff[14:12]
            && advance_time_ff == 19'(wdata_d2_ff[3:0]) << wdata_d2_ff[6:4];
    endproperty
    AST_UNUSED_RD: assert property (req.rd_en && req.addr inside {[8'h37:8'h5F], [8'h61:8'h8F]}
        |=> rdata_ff == '0) else $error("unused read nonzero");
    AST_INHIBIT_RD: assert property (req.rd_en && req.addr == 8'h60 |=> rdata_ff == '0)
        else $error("inhibit readable");
    AST_B_TOP: assert property (req.rd_en && req.addr == 8'h91 |=> !rdata_ff[15])
        else $error("reserved bit readable");
    AST_RVALID: assert property (req.rd_en |=> rvalid_ff ##1 rvalid_ff == $past(req.rd_en))
        else $error("read strobe wrong");
    AST_RUN: assert property (p_run)
        else $error("motor run wrong");
    AST_WORD_A: assert property (p_a)
        else $error("word a decode wrong");
    AST_WORD_B: assert property (p_b)
        else $error("word b decode wrong");
    AST_NVM_SEL: assert property (nvm_single_access_addr == 8'h90 |=> nvm_target_setup_a_ff)
        else $error("single access target missed");
    cover property (req.wr_en && req.addr == 8'h60 && req.wdata[15]);
    cover property (rvalid_ff && rdata_ff != '0);
    cover property ($rose(tach_output));
endmodule : mcr_bank_asserts
bind mcr_bank mcr_bank_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.clk_sys, .reset, .rvalid_ff,
    .closed_loop, .elec_pulse, .tach_output, .nvm_target_setup_a_ff, .motor_run_ff, .cycle_adjust_select_ff,
    .advance_mode_select_ff, .req, .rdata_ff, .nvm_single_access_addr, .dither_select_ff, .dither_pct_ff,
    .resistance_param_ff, .bemf_const_ff, .advance_time_ff);
`default_nettype wire

//--- bench/motor_config_register_bank_tb_top.sv
// self-checking bench for the motor config bank
`timescale 1ns/1ps
`default_nettype none
module motor_config_register_bank_tb_top;
    logic clk_sys, reset, closed_loop, elec_pulse, rvalid_ff, nvm_target_setup_a_ff, motor_run_ff, inh;
    logic cycle_adjust_select_ff, advance_mode_select_ff, tach_output;
    logic [7:0] nvm_single_access_addr, ad, cls = 8'hE2, ens = 8'h2B;
    logic [15:0] rdata_ff, a, b, wd;
    logic [1:0] dither_select_ff;
    logic [4:0] dither_pct_ff;
    logic [18:0] resistance_param_ff, bemf_const_ff, advance_time_ff;
    logic [7:0] tbl [8] = '{8'h37, 8'h5F, 8'h61, 8'h8F, 8'h60, 8'h90, 8'h91, 8'hC3};
    logic [15:0] tw [8] = '{16'h2100, 16'h2200, 16'h2100, 16'h0000, 16'h1100, 16'h1500, 16'h3100, 16'h0000};
    mcr_pkg::mcr_req_type req;
    int n_errors = 0, n_checks = 0, cycles = 0;
    mcr_host_model host_u (.clk_sys, .req);
    mcr_bank dut_u (.clk_sys, .reset, .req, .rdata_ff, .rvalid_ff, .nvm_single_access_addr, .nvm_target_setup_a_ff,
        .closed_loop, .elec_pulse, .motor_run_ff, .dither_select_ff, .dither_pct_ff, .cycle_adjust_select_ff,
        .resistance_param_ff, .bemf_const_ff, .advance_time_ff, .advance_mode_select_ff, .tach_output);
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (++cycles == 3000) begin
        n_errors++;
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic check_all();
        chk("run", 19'(!inh), 19'(motor_run_ff));
        chk("dither", 19'(a[15:14]), 19'(dither_select_ff));
        chk("pct", 19'(5 * a[15:14]), 19'(dither_pct_ff));
        chk("cycadj", 19'(a[7]), 19'(cycle_adjust_select_ff));
        chk("res", 19'(a[3:0]) << a[6:4], resistance_param_ff);
        chk("bemf", 19'(b[11:8]) << b[14:12], bemf_const_ff);
        chk("adv", 19'(b[3:0]) << b[6:4], advance_time_ff);
        chk("advmode", 19'(b[7]), 19'(advance_mode_select_ff));
    endtask : check_all
    // six electrical pulses, count tach toggles
    task automatic tach(input logic [15:0] w, input logic cl, input logic en);
        int t;
        logic p;
        closed_loop = cl;
        host_u.xfer(1, 8'h90, w);
        a = w;
        repeat (3) @(posedge clk_sys) #1;
        t = 0;
        p = tach_output;
        repeat (6) begin
            elec_pulse = 1;
            @(posedge clk_sys) #1;
            elec_pulse = 0;
            @(posedge clk_sys) #1;
            t += int'(tach_output !== p);
            p = tach_output;
        end
        chk("tach", en ? 19'(6 / (w[11:8] + 1)) : 19'h00000, 19'(t));
    endtask : tach
    initial begin
        reset = 1;
        closed_loop = 0;
        elec_pulse = 0;
        nvm_single_access_addr = 8'h00;
        a = 0;
        b = 0;
        inh = 0;
        void'($urandom(32'h1633));
        repeat (2) @(posedge clk_sys) #1;
        reset = 0;
        @(posedge clk_sys) #1;
        check_all();
        host_u.xfer(0, 8'h91, 16'h0000);
        chk("rst", 19'h00000, 19'(rdata_ff));
        for (int i = 0; i < 48; i++) begin
            ad = i < 8 ? tbl[i] : ($urandom % 4 == 0 ? 8'($urandom) : tbl[$urandom % 8]);
            wd = i < 8 ? 16'hFFFF : 16'($urandom);
            if (i >= 8 && ad == 8'h90) wd[6:0] = host_u.quant(11'($urandom));
            host_u.xfer(1, ad, wd);
            chk("rvalid", 19'h00000, 19'(rvalid_ff));
            if (ad == 8'h60) inh = wd[15];
            if (ad == 8'h90) a = wd;
            if (ad == 8'h91) b = {1'b0, wd[14:0]};
            nvm_single_access_addr = $urandom % 2 ? 8'h90 : 8'($urandom);
            host_u.xfer(0, ad, 16'h0000);
            chk("rvalid", 19'h00001, 19'(rvalid_ff));
            chk("rdata", 19'(ad == 8'h90 ? a : ad == 8'h91 ? b : 16'h0000), 19'(rdata_ff));
            chk("nvmsel", 19'(nvm_single_access_addr == 8'h90), 19'(nvm_target_setup_a_ff));
            check_all();
        end
        host_u.xfer(1, 8'h60, 16'h0000);
        inh = 0;
        for (int i = 0; i < 8; i++) begin
            if (i == 7) host_u.xfer(1, 8'h60, 16'h8000);
            inh = i == 7;
            tach(tw[i], cls[i], ens[i]);
        end
        check_all();
        wrap_up();
    end
endmodule : motor_config_register_bank_tb_top
`default_nettype wire
